// [common/tat_pkg.sv]
`default_nettype none
package tat_pkg;
   // register bus geometry
   localparam int TAT_ADDR_W = 8;
   localparam int TAT_DATA_W = 32;

   // register offsets and reset values
   localparam logic [7:0]  TAT_OFS_PROFILE   = 8'h98;
   localparam logic [7:0]  TAT_OFS_TUNING    = 8'h9a;
   localparam logic [31:0] TAT_RST_PROFILE   = 32'h0000_0000;
   localparam logic [31:0] TAT_RST_TUNING    = 32'h0000_0000;
   localparam logic [31:0] TAT_RDATA_UNMAPPED = 32'h0000_0000;

   // profile register field layout
   localparam int TAT_NUM_STEPS   = 5;
   localparam int TAT_STEP_W      = 3;
   localparam int TAT_STEP3_LSB   = 19;
   localparam int TAT_STEP4_LSB   = 16;
   localparam int TAT_STEP5_LSB   = 13;
   localparam int TAT_STEP6_LSB   = 10;
   localparam int TAT_STEP7_LSB   = 7;
   localparam int TAT_LEAD_LSB    = 5;
   localparam int TAT_LEAD_W      = 2;
   localparam int TAT_PARITY_BIT  = 31;

   // tuning register field layout
   localparam int TAT_HANDOFF_LSB = 22;
   localparam int TAT_NEG_LSB     = 16;
   localparam int TAT_HYST_BIT    = 15;
   localparam int TAT_BEMF_LSB    = 10;
   localparam int TAT_BEMF_W      = 5;
   localparam int TAT_CYC_LSB     = 7;
   localparam int TAT_ZC_LSB      = 2;
   localparam int TAT_DIV_LSB     = 0;

   // duty ladder in hundredths of a percent
   localparam int TAT_DUTY_W = 14;
   localparam logic [13:0] TAT_DUTY_LADDER [8] = '{
      14'h0000, 14'h1388, 14'h1d4c, 14'h20b7,
      14'h222e, 14'h249f, 14'h2616, 14'h26ac};

   // advance angle in degrees per code step
   localparam logic [4:0] TAT_LEAD_STEP = 5'h05;
   // open-loop transfer cycles
   localparam logic [4:0] TAT_HANDOFF [4] = '{5'h03, 5'h06, 5'h0c, 5'h18};
   // surge guard limits, signed counts
   localparam logic signed [7:0] TAT_NEG_LIMIT [8] = '{
      8'sh00, 8'shd8, 8'she2, 8'shec, 8'shf6, 8'sh0a, 8'sh14, 8'sh1e};
   localparam logic signed [7:0] TAT_HYST [2] = '{8'sh14, 8'sh0a};
   // back-emf threshold step
   localparam logic [12:0] TAT_BEMF_STEP = 13'h00c8;
   // speed-detect cycle threshold base and step
   localparam logic [4:0] TAT_CYC_BASE = 5'h02;
   localparam logic [4:0] TAT_CYC_STEP = 5'h03;
   // open-loop crossing angle in degrees
   localparam logic [4:0] TAT_ZC_ANGLE [4] = '{5'h05, 5'h08, 5'h0c, 5'h0f};
   // quick launch divider base
   localparam logic [3:0] TAT_DIV_BASE = 4'h1;
endpackage
`default_nettype wire

// [common/tat_duty_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface tat_duty_if;
   import tat_pkg::*;
   logic [TAT_STEP_W-1:0] code;  // step duty code
   logic [TAT_DUTY_W-1:0] duty;  // decoded duty
   modport src (output code, input duty);
   modport dec (input code, output duty);
endinterface
`default_nettype wire

// [rtl/tat_duty_decode.sv]
`timescale 1ns/10ps
`default_nettype none
module tat_duty_decode
   import tat_pkg::*;
(
   tat_duty_if.dec bus  // code in, duty out
);
   // eight-entry ladder lookup
   assign bus.duty = TAT_DUTY_LADDER[bus.code];  // R1 R2
endmodule
`default_nettype wire

// [rtl/tat_tuning_regs.sv]
// Operation
// R1: steps 3, 5, 6 and 7 decode their 3-bit codes to duties 0, 50, 75, 83.75, 87.5, 93.75, 97.5, 99 percent.
// R2: step 4 at bits 18-16 decodes with the same eight-entry duty ladder.
// R3: the 2-bit advance field at bits 6-5 gives 0, 5, 10 or 15 degrees of commutation advance.
// R4: the tuning register lives at 9Ah, resets to zero and every bit is read/write.
// R5: the transfer field at bits 23-22 gives 3, 6, 12 or 24 open-loop transfer cycles.
// R6: the negative surge limit field at bits 18-16 maps to 0, -40, -30, -20, -10, 10, 20, 30.
// R7: the hysteresis bit 15 selects 20 or 10, and the positive limit is hysteresis plus negative limit.
// R8: the back-emf threshold is 200 times the 5-bit code at bits 14-10.
// R9: the speed-detect cycle threshold at bits 9-7 is 2, 5, 8 ... 23 cycles.
// R10: open-loop crossing detection starts above 5, 8, 12 or 15 degrees from bits 3-2.
// R11: the quick launch rate divider at bits 1-0 is 1, 2, 4 or 8.
// R12: the duty profile register lives at 98h, resets to zero and bit 31 is a parity bit.
// R13: software keeps reserved fields at zero and the decoders never look at them.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module tat_tuning_regs
   import tat_pkg::*;
#(
   parameter int ADDR_W = TAT_ADDR_W,
   parameter int DATA_W = TAT_DATA_W
)(
   input  wire logic                    i_clock,          // 20 MHz clock
   input  wire logic                    i_rst_n,          // sync reset, low
   input  wire logic [ADDR_W-1:0]       i_addr,           // register address
   input  wire logic [DATA_W-1:0]       i_wdata,          // write data
   input  wire logic                    i_wr,             // write strobe
   input  wire logic                    i_rd,             // read strobe
   output logic [DATA_W-1:0]            o_rdata,          // read data, next cycle
   output logic [TAT_NUM_STEPS-1:0][TAT_DUTY_W-1:0]
                                        o_tri_phase_duty, // steps 3..7, 0.01 %
   output logic [4:0]                   o_commutation_advance_angle, // degrees
   output logic                         o_profile_parity, // profile parity bit
   output logic [4:0]                   o_open_loop_transfer_cycles, // cycles
   output logic signed [7:0]            o_surge_guard_negative_limit, // counts
   output logic signed [7:0]            o_surge_guard_hysteresis, // counts
   output logic signed [7:0]            o_surge_guard_positive_limit, // counts
   output logic [12:0]                  o_speed_detect_backemf_threshold, // counts
   output logic [4:0]                   o_speed_detect_cycle_threshold, // cycles
   output logic [4:0]                   o_open_loop_crossing_angle, // degrees
   output logic [3:0]                   o_quick_launch_rate_divider // rate
);

   // elaboration checks
   if (ADDR_W < 8) begin : g_chk_addr
      $error("address width too small for the register offsets");
   end
   if (DATA_W != 32) begin : g_chk_data
      $error("register width must be 32");
   end

   // register storage
   logic [31:0] profile_q;
   logic [31:0] tuning_q;
   logic [31:0] rdata_q;

   // address decode
   wire hit_profile = (i_addr == ADDR_W'(TAT_OFS_PROFILE));
   wire hit_tuning  = (i_addr == ADDR_W'(TAT_OFS_TUNING));
   wire wr_profile  = i_wr & hit_profile;
   wire wr_tuning   = i_wr & hit_tuning;

   // read data selection
   wire [31:0] rdata_d = !i_rd        ? rdata_q :
                         hit_profile  ? profile_q :
                         hit_tuning   ? tuning_q :
                                        TAT_RDATA_UNMAPPED;

   // register writes, whole word, reserved bits kept as written
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         profile_q <= TAT_RST_PROFILE;  // R12
         tuning_q  <= TAT_RST_TUNING;   // R4
      end else begin
         if (wr_profile) begin
            profile_q <= i_wdata;  // R12
         end
         if (wr_tuning) begin
            tuning_q <= i_wdata;   // R4
         end
      end
   end

   // read data register, held between reads
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rdata_q <= TAT_RDATA_UNMAPPED;
      end else begin
         rdata_q <= rdata_d;  // R4 R12
      end
   end
   assign o_rdata = rdata_q;

   // step duty codes, only named fields reach the decoders
   localparam int STEP_LSB [TAT_NUM_STEPS] = '{
      TAT_STEP3_LSB, TAT_STEP4_LSB, TAT_STEP5_LSB,
      TAT_STEP6_LSB, TAT_STEP7_LSB};
   logic [TAT_NUM_STEPS-1:0][TAT_DUTY_W-1:0] duty_d;

   // one ladder decoder per step
   for (genvar s = 0; s < TAT_NUM_STEPS; s++) begin : g_step
      tat_duty_if duty_bus ();
      assign duty_bus.code = profile_q[STEP_LSB[s] +: TAT_STEP_W];  // R1 R2 R13
      assign duty_d[s]     = duty_bus.duty;
      tat_duty_decode u_dec (
         .bus (duty_bus.dec)
      );
   end

   // profile advance and tuning field extraction
   wire [1:0] lead_code    = profile_q[TAT_LEAD_LSB +: TAT_LEAD_W];  // R13
   wire [1:0] handoff_code = tuning_q[TAT_HANDOFF_LSB +: 2];        // R13
   wire [2:0] neg_code     = tuning_q[TAT_NEG_LSB +: 3];
   wire       hyst_code    = tuning_q[TAT_HYST_BIT];
   wire [4:0] bemf_code    = tuning_q[TAT_BEMF_LSB +: TAT_BEMF_W];
   wire [2:0] cyc_code     = tuning_q[TAT_CYC_LSB +: 3];
   wire [1:0] zc_code      = tuning_q[TAT_ZC_LSB +: 2];
   wire [1:0] div_code     = tuning_q[TAT_DIV_LSB +: 2];

   // field decoders
   wire [4:0] lead_d = 5'(TAT_LEAD_STEP * 5'(lead_code));  // R3
   wire [4:0] handoff_d = TAT_HANDOFF[handoff_code];         // R5
   wire signed [7:0] neg_d  = TAT_NEG_LIMIT[neg_code];       // R6
   wire signed [7:0] hyst_d = TAT_HYST[hyst_code];           // R7
   wire signed [7:0] pos_d  = 8'(hyst_d + neg_d);            // R7
   wire [12:0] bemf_d = 13'(TAT_BEMF_STEP * 13'(bemf_code)); // R8
   wire [4:0] cyc_d = 5'(TAT_CYC_BASE + TAT_CYC_STEP * 5'(cyc_code));  // R9
   wire [4:0] zc_d  = TAT_ZC_ANGLE[zc_code];                 // R10
   wire [3:0] div_d = 4'(TAT_DIV_BASE << div_code);          // R11

   // decoded values registered toward the algorithm
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int s = 0; s < TAT_NUM_STEPS; s++) begin
            o_tri_phase_duty[s] <= TAT_DUTY_LADDER[0];
         end
         o_commutation_advance_angle  <= 5'h00;
         o_profile_parity             <= 1'b0;
         o_open_loop_transfer_cycles  <= TAT_HANDOFF[0];
         o_surge_guard_negative_limit <= TAT_NEG_LIMIT[0];
         o_surge_guard_hysteresis     <= TAT_HYST[0];
         o_surge_guard_positive_limit <= TAT_HYST[0];
      end else begin
         o_tri_phase_duty             <= duty_d;     // R1 R2
         o_commutation_advance_angle  <= lead_d;     // R3
         o_profile_parity             <= profile_q[TAT_PARITY_BIT];  // R12
         o_open_loop_transfer_cycles  <= handoff_d;  // R5
         o_surge_guard_negative_limit <= neg_d;      // R6
         o_surge_guard_hysteresis     <= hyst_d;     // R7
         o_surge_guard_positive_limit <= pos_d;      // R7
      end
   end

   // speed detect and startup values
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_speed_detect_backemf_threshold <= 13'h0000;
         o_speed_detect_cycle_threshold   <= TAT_CYC_BASE;
         o_open_loop_crossing_angle       <= TAT_ZC_ANGLE[0];
         o_quick_launch_rate_divider      <= TAT_DIV_BASE;
      end else begin
         o_speed_detect_backemf_threshold <= bemf_d;  // R8
         o_speed_detect_cycle_threshold   <= cyc_d;   // R9
         o_open_loop_crossing_angle       <= zc_d;    // R10
         o_quick_launch_rate_divider      <= div_d;   // R11
      end
   end

   // checks on the register behaviour
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   // a write followed by two settle cycles
   sequence s_tune_wr;
      wr_tuning ##1 !wr_tuning ##1 !wr_tuning;
   endsequence
   sequence s_prof_wr;
      wr_profile ##1 !wr_profile ##1 !wr_profile;
   endsequence
   // a write answered at once by a read of the same word
   sequence s_tune_wr_rd;
      wr_tuning ##1 (i_rd && hit_tuning && !i_wr);
   endsequence
   sequence s_prof_wr_rd;
      wr_profile ##1 (i_rd && hit_profile && !i_wr);
   endsequence

   // after reset release both registers are zero
   reset_zero_a : assert property ($rose(i_rst_n) |-> // R4
         (tuning_q == 32'h0 && profile_q == 32'h0))
      else $error("registers not zero after reset");

   // decoded profile outputs cleared by reset
   reset_prof_a : assert property ($rose(i_rst_n) |-> // R12
         (o_tri_phase_duty == '0 && o_commutation_advance_angle == 5'h00
          && !o_profile_parity))
      else $error("profile outputs not cleared by reset");

   // decoded tuning outputs at their zero-code values after reset
   reset_tune_a : assert property ($rose(i_rst_n) |-> // R4
         (o_open_loop_transfer_cycles == 5'h03 && o_surge_guard_negative_limit == 8'sh00
          && o_surge_guard_positive_limit == 8'sh14 && o_speed_detect_cycle_threshold == 5'h02
          && o_open_loop_crossing_angle == 5'h05 && o_quick_launch_rate_divider == 4'h1))
      else $error("tuning outputs not at reset values");

   // tuning write lands in storage
   tune_write_a : assert property (wr_tuning |=> tuning_q == $past(i_wdata)) // R4
      else $error("tuning write lost");

   // tuning write then read back of the full word
   tune_rdback_a : assert property (s_tune_wr_rd |=> o_rdata == $past(i_wdata, 2)) // R4
      else $error("tuning word not read back");

   // profile write lands in storage
   prof_write_a : assert property (wr_profile |=> profile_q == $past(i_wdata)) // R12
      else $error("profile write lost");

   // profile write then read back of the full word
   prof_rdback_a : assert property (s_prof_wr_rd |=> o_rdata == $past(i_wdata, 2)) // R12
      else $error("profile word not read back");

   // a read of the tuning word returns its storage
   rd_tune_a : assert property (i_rd && hit_tuning |=> o_rdata == $past(tuning_q)) // R4
      else $error("tuning read data wrong");

   // a read of the profile word returns its storage
   rd_prof_a : assert property (i_rd && hit_profile |=> o_rdata == $past(profile_q)) // R12
      else $error("profile read data wrong");

   // unmapped reads answer zero
   unmapped_rd_a : assert property (i_rd && !hit_profile && !hit_tuning
         |=> o_rdata == TAT_RDATA_UNMAPPED)
      else $error("unmapped read not zero");

   // read data hold between reads
   rdata_hold_a : assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data moved without a read");

   // writes to unmapped places leave both registers alone
   stray_write_a : assert property (i_wr && !hit_profile && !hit_tuning |=> // R4 R12
         ($stable(profile_q) && $stable(tuning_q)))
      else $error("stray write changed a register");

   // step 3 ladder
   step3_duty_a : assert property (s_prof_wr |-> // R1
         o_tri_phase_duty[0] == TAT_DUTY_LADDER[$past(i_wdata[21:19], 2)])
      else $error("step 3 duty wrong");

   // step 5 ladder
   step5_duty_a : assert property (s_prof_wr |-> // R1
         o_tri_phase_duty[2] == TAT_DUTY_LADDER[$past(i_wdata[15:13], 2)])
      else $error("step 5 duty wrong");

   // step 6 ladder
   step6_duty_a : assert property (s_prof_wr |-> // R1
         o_tri_phase_duty[3] == TAT_DUTY_LADDER[$past(i_wdata[12:10], 2)])
      else $error("step 6 duty wrong");

   // step 7 ladder
   step7_duty_a : assert property (s_prof_wr |-> // R1
         o_tri_phase_duty[4] == TAT_DUTY_LADDER[$past(i_wdata[9:7], 2)])
      else $error("step 7 duty wrong");

   // step 4 ladder
   step4_duty_a : assert property (s_prof_wr |-> // R2
         o_tri_phase_duty[1] == TAT_DUTY_LADDER[$past(i_wdata[18:16], 2)])
      else $error("step 4 duty wrong");

   // top of ladder is 99 percent
   duty_top_a : assert property (wr_profile && i_wdata[18:16] == 3'h7 ##1 !wr_profile |=> // R2
         o_tri_phase_duty[1] == 14'h26ac)
      else $error("step 4 top duty wrong");

   // advance angle in 5 degree steps
   lead_angle_a : assert property (s_prof_wr |-> // R3
         o_commutation_advance_angle == 5'(5 * $past(i_wdata[6:5], 2)))
      else $error("advance angle wrong");

   // largest advance is 15 degrees
   lead_top_a : assert property (wr_profile && i_wdata[6:5] == 2'h3 ##1 !wr_profile |=> // R3
         o_commutation_advance_angle == 5'h0f)
      else $error("largest advance wrong");

   // parity bit copied out unchanged
   parity_copy_a : assert property (s_prof_wr |-> // R12
         o_profile_parity == $past(i_wdata[31], 2))
      else $error("parity copy wrong");

   // transfer cycles double per code
   transfer_cyc_a : assert property (s_tune_wr |-> // R5
         o_open_loop_transfer_cycles == 5'(5'h03 << $past(i_wdata[23:22], 2)))
      else $error("transfer cycles wrong");

   // longest transfer is 24 cycles
   xfer_top_a : assert property (wr_tuning && i_wdata[23:22] == 2'h3 ##1 !wr_tuning |=> // R5
         o_open_loop_transfer_cycles == 5'h18)
      else $error("longest transfer wrong");

   // negative limit table
   neg_limit_a : assert property (s_tune_wr |-> // R6
         o_surge_guard_negative_limit == TAT_NEG_LIMIT[$past(i_wdata[18:16], 2)])
      else $error("negative limit wrong");

   // code one gives minus forty
   neg_low_a : assert property (wr_tuning && i_wdata[18:16] == 3'h1 ##1 !wr_tuning |=> // R6
         o_surge_guard_negative_limit == 8'shd8)
      else $error("lowest negative limit wrong");

   // hysteresis select
   hyst_sel_a : assert property (s_tune_wr |-> // R7
         o_surge_guard_hysteresis == ($past(i_wdata[15], 2) ? 8'sh0a : 8'sh14))
      else $error("hysteresis wrong");

   // positive limit tracks hysteresis plus negative limit
   pos_limit_a : assert property (s_tune_wr |-> // R7
         o_surge_guard_positive_limit == 8'(o_surge_guard_negative_limit
               + ($past(i_wdata[15], 2) ? 8'sh0a : 8'sh14)))
      else $error("positive limit wrong");

   // back-emf threshold scaling
   bemf_thr_a : assert property (s_tune_wr |-> // R8
         o_speed_detect_backemf_threshold == 13'(200 * $past(i_wdata[14:10], 2)))
      else $error("back-emf threshold wrong");

   // top back-emf code gives 6200
   bemf_top_a : assert property (wr_tuning && i_wdata[14:10] == 5'h1f ##1 !wr_tuning |=> // R8
         o_speed_detect_backemf_threshold == 13'h1838)
      else $error("top back-emf threshold wrong");

   // cycle threshold steps of three from two
   cyc_thr_a : assert property (s_tune_wr |-> // R9
         o_speed_detect_cycle_threshold == 5'(2 + 3 * $past(i_wdata[9:7], 2)))
      else $error("cycle threshold wrong");

   // top cycle code gives 23
   cyc_top_a : assert property (wr_tuning && i_wdata[9:7] == 3'h7 ##1 !wr_tuning |=> // R9
         o_speed_detect_cycle_threshold == 5'h17)
      else $error("top cycle threshold wrong");

   // crossing angle table
   zc_angle_a : assert property (s_tune_wr |-> // R10
         o_open_loop_crossing_angle == TAT_ZC_ANGLE[$past(i_wdata[3:2], 2)])
      else $error("crossing angle wrong");

   // divider is a power of two
   rate_div_a : assert property (s_tune_wr |-> // R11
         o_quick_launch_rate_divider == 4'(4'h1 << $past(i_wdata[1:0], 2)))
      else $error("rate divider wrong");

endmodule
`default_nettype wire

// [bench/tat_tuning_regs_test.sv]
`timescale 1ns/10ps
`default_nettype none
module tat_tuning_regs_test
   import tat_pkg::*;
;
   logic                          i_clock;
   logic                          i_rst_n;
   logic [7:0]                    i_addr;
   logic [31:0]                   i_wdata;
   logic                          i_wr;
   logic                          i_rd;
   logic [31:0]                   o_rdata;
   logic [4:0][13:0]              duty;
   logic [4:0]                    adv;
   logic                          par;
   logic [4:0]                    xfer;
   logic signed [7:0]             neg;
   logic signed [7:0]             hyst;
   logic signed [7:0]             pos;
   logic [12:0]                   bemf;
   logic [4:0]                    cyc;
   logic [4:0]                    zc;
   logic [3:0]                    div;
   int                            bad_count;
   int                            cmp_count;
   logic [31:0]                   lfsr_q;
   logic [31:0]                   prof;
   logic [31:0]                   tune;

   tat_tuning_regs DUT (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tri_phase_duty(duty),
      .o_commutation_advance_angle(adv), .o_profile_parity(par),
      .o_open_loop_transfer_cycles(xfer), .o_surge_guard_negative_limit(neg),
      .o_surge_guard_hysteresis(hyst), .o_surge_guard_positive_limit(pos),
      .o_speed_detect_backemf_threshold(bemf), .o_speed_detect_cycle_threshold(cyc),
      .o_open_loop_crossing_angle(zc), .o_quick_launch_rate_divider(div));

   // clock at 50 ns period
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   // pseudo random source
   function automatic logic [31:0] next_rand();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction

   // expected duty in hundredths of a percent
   function automatic logic [31:0] f_duty(input logic [2:0] c);
      logic [13:0] t [8] = '{14'h0000, 14'h1388, 14'h1d4c, 14'h20b7,
                              14'h222e, 14'h249f, 14'h2616, 14'h26ac};
      return {18'h00000, t[c]};
   endfunction

   // expected negative surge limit, signed
   function automatic logic signed [7:0] f_neg(input logic [2:0] c);
      logic signed [7:0] t [8] = '{8'sh00, 8'shd8, 8'she2, 8'shec,
                                    8'shf6, 8'sh0a, 8'sh14, 8'sh1e};
      return t[c];
   endfunction

   // expected crossing angle in degrees
   function automatic logic [31:0] f_zc(input logic [1:0] c);
      logic [31:0] t [4] = '{32'h05, 32'h08, 32'h0c, 32'h0f};
      return t[c];
   endfunction

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask

   // write strobe followed at once by a read of the same word
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
      i_rd    <= 1'b1;
      @(posedge i_clock);
      i_rd    <= 1'b0;
      @(negedge i_clock);
      chk(o_rdata, d);
   endtask

   // one-cycle read strobe, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      @(negedge i_clock);
      chk(o_rdata, exp);
   endtask

   // decoded outputs against shadow copies
   task automatic chk_dec();
      logic signed [7:0] he;
      logic signed [7:0] pe;
      he = tune[15] ? 8'sh0a : 8'sh14;
      pe = he + f_neg(tune[18:16]);
      for (int k = 0; k < 5; k++) begin
         chk(duty[k], f_duty(prof[21-3*k -: 3]));
      end
      chk(adv, 32'(prof[6:5]) * 32'h5);
      chk(par, prof[31]);
      chk(xfer, 32'h3 << tune[23:22]);
      chk(neg, f_neg(tune[18:16]));
      chk(hyst, he);
      chk(pos, pe);
      chk(bemf, 32'(tune[14:10]) * 32'hc8);
      chk(cyc, 32'h2 + 32'(tune[9:7]) * 32'h3);
      chk(zc, f_zc(tune[3:2]));
      chk(div, 32'h1 << tune[1:0]);
   endtask

   // write both registers, let decode land, read back
   task automatic load(input logic [31:0] p, input logic [31:0] t);
      prof = p;
      tune = t;
      wr_rd(8'h98, p);
      wr_rd(8'h9a, t);
      @(posedge i_clock);
      @(negedge i_clock);
      chk_dec();
      rd(8'h98, prof);
      rd(8'h9a, tune);
   endtask

   // synchronous reset for two edges
   task automatic do_reset();
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      prof = 32'h0000_0000;
      tune = 32'h0000_0000;
      @(negedge i_clock);
      chk_dec();
      rd(8'h98, 32'h0000_0000);
      rd(8'h9a, 32'h0000_0000);
   endtask

   // verdict and end of run
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      i_rst_n   = 1'b0;
      i_addr    = 8'h00;
      i_wdata   = 32'h0000_0000;
      i_wr      = 1'b0;
      i_rd      = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      lfsr_q    = 32'h0001_4d2e;
      prof      = 32'h0000_0000;
      tune      = 32'h0000_0000;
      do_reset();
      // random fields, profile bits 4-0 and tuning bits 30-24, 21-19, 6-4 kept at zero
      for (int n = 0; n < 40; n++) begin
         load(next_rand() & 32'hffff_ffe0, next_rand() & 32'h80c7_ff8f);
      end
      // every bit set, reserved too
      load(32'hffff_ffff, 32'hffff_ffff);
      // unmapped places change nothing and read zero
      wr(8'h99, 32'h0000_0000);
      wr(8'h9b, 32'h0000_0000);
      rd(8'h99, 32'h0000_0000);
      rd(8'h98, 32'hffff_ffff);
      rd(8'h9a, 32'hffff_ffff);
      chk_dec();
      // reset in mid-run clears both registers
      do_reset();
      load(32'h0000_0000, 32'h7fff_ffff);
      wrap_up();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge i_clock);
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
